// >>> rtl/fieldbus_defs.svh
// offsets, field codes, reset values and timing counts of the cyclic slave
// Function
// - left lamp shows interface health states
// - right lamp shows network exchange state
// - left is interface, right is network
// - switches binary, position one least significant
// - switches read only at power-up
// - nonzero switch below 128 wins at power-up
// - switch 128 up keeps master address
// - all switches off gives address 126
// - supply 32-byte process input image
// - accept 24-byte process output image
// - supply 14-byte device information block
// - real fields 32-bit float, low byte first
// - integer fields are 16 bits, two bytes
// - report and adopt set point in force
// - clamp set point to full scale
// - custom range half to full native
// - valve mode 1 auto, 2 closed, 3 purge
// - native range read-only, ignores master
// - measured flow read-only from measurement
// - support freeze, sync and baud detection
// - trigger value on zero field zeroes
// - trigger value on restore field restores defaults
// - quality field 0 bad, 1 good
// - origin 1 digital, higher analog
`ifndef FIELDBUS_DEFS_SVH
`define FIELDBUS_DEFS_SVH
// master-to-slave image byte offsets
`define SP_OUT_OFS 5'h00
`define VALVE_OUT_OFS 5'h04
`define RANGE_OUT_OFS 5'h06
`define UNIT_OUT_OFS 5'h0A
`define ORIGIN_OUT_OFS 5'h0C
`define GAIN_OUT_OFS 5'h0E
`define MEDIUM_OUT_OFS 5'h12
`define ZERO_OUT_OFS 5'h14
`define RESTORE_OUT_OFS 5'h16
`define OUT_IMG_BYTES 24
// slave-to-master image byte offsets
`define FLOW_IN_OFS 6'h00
`define SP_IN_OFS 6'h04
`define VALVE_IN_OFS 6'h08
`define POWER_IN_OFS 6'h0A
`define RANGE_IN_OFS 6'h0C
`define NATIVE_IN_OFS 6'h10
`define UNIT_IN_OFS 6'h14
`define ORIGIN_IN_OFS 6'h16
`define GAIN_IN_OFS 6'h18
`define MEDIUM_IN_OFS 6'h1C
`define QUALITY_IN_OFS 6'h1E
`define SERIAL_IN_OFS 6'h20
`define TYPE_IN_OFS 6'h28
`define VERSION_IN_OFS 6'h2A
`define IN_IMG_BYTES 46
// codes and reset values
`define VALVE_AUTO 16'h0001
`define VALVE_CLOSED 16'h0002
`define VALVE_PURGE 16'h0003
`define ORIGIN_DIGITAL 16'h0001
`define CMD_TRIGGER 16'h00A5
`define QUALITY_BAD 16'h0000
`define QUALITY_GOOD 16'h0001
`define GAIN_DEFAULT 32'h3F800000
`define UNIT_DEFAULT 16'h0001
`define MEDIUM_DEFAULT 16'h0001
`define SWITCH_HIGH_LIMIT 8'h80
`define DEFAULT_STATION 7'h7E
// timing
`define SYS_CLK_PERIOD_NS 10
`define LED_FLASH_MS 250
`define LED_FLASH_CYCLES (`LED_FLASH_MS * 1000000 / `SYS_CLK_PERIOD_NS)
`endif

// >>> rtl/fieldbus_pkg.sv
// types shared by the cyclic slave
package fieldbus_pkg;
  typedef struct packed {
    logic last;
    logic [4:0] addr;
    logic [7:0] data;
  } wr_word_t;
  typedef struct packed {
    logic green;
    logic red;
  } led_t;
  typedef enum logic [3:0] {
    IF_INIT = 4'h1,
    IF_OPER = 4'h2,
    IF_SOFT = 4'h4,
    IF_HARD = 4'h8
  } if_state_t;
  typedef enum logic [2:0] {
    NET_OFF = 3'h1,
    NET_XCHG = 3'h2,
    NET_LOST = 3'h4
  } net_state_t;
endpackage

// >>> rtl/fieldbus_slave_cyclic_data.sv
// cyclic data slave: write fifo, field images, addressing, lamps
`include "fieldbus_defs.svh"

module write_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("fifo depth must be a power of two, width positive");
  end
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wp, rp;
  logic [AW:0] count;
  logic push, pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp];
  always_ff @(posedge sys_clk) begin
    if (ce && push) begin
      mem[wp] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      if (push && !pop) begin
        count <= count + 1'b1;
        in_ready <= (count != (AW+1)'(DEPTH - 1));
        out_valid <= 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
        in_ready <= 1'b1;
        out_valid <= (count != (AW+1)'(1));
      end else begin
        in_ready <= (count != (AW+1)'(DEPTH));
        out_valid <= (count != '0);
      end
    end
  end
endmodule

module fieldbus_slave_cyclic_data
  import fieldbus_pkg::*;
#(
  parameter int FLASH_CYCLES = `LED_FLASH_CYCLES,
  parameter int FIFO_DEPTH = 8,
  parameter logic [15:0] PRODUCT_CODE = 16'h0042, // arbitrary value
  parameter logic [31:0] VERSION_VALUE = 32'h3F800000 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire wr_word_t wr_word,
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic freeze_req,
  input wire logic unfreeze_req,
  input wire logic sync_req,
  input wire logic unsync_req,
  input wire logic bus_rx,
  output logic [15:0] baud_period,
  input wire logic [7:0] addr_switch,
  input wire logic assign_valid,
  input wire logic [6:0] assign_addr,
  input wire logic [6:0] saved_addr,
  output logic save_strobe,
  output logic [6:0] station_addr,
  input wire logic init_done,
  input wire logic fault_recov,
  input wire logic fault_hard,
  input wire logic data_exch,
  input wire logic conn_lost,
  output led_t led_left,
  output led_t led_right,
  input wire logic [31:0] meas_flow,
  input wire logic [15:0] meas_power,
  input wire logic meas_good,
  input wire logic [31:0] native_range,
  input wire logic [63:0] serial_text,
  input wire logic apply_ready,
  output logic [31:0] setpoint,
  output logic [15:0] valve_op,
  output logic [31:0] custom_range,
  output logic [15:0] eng_unit,
  output logic [15:0] sp_origin,
  output logic [31:0] calib_gain,
  output logic [15:0] medium_sel,
  output logic valve_auto,
  output logic valve_close,
  output logic valve_purge,
  output logic origin_digital,
  output logic range_update,
  output logic zero_pulse,
  output logic restore_pulse
);
  initial begin
    if (FLASH_CYCLES < 2) $error("flash period too short");
  end

  // master writes queue here; draining stalls while the instrument is busy
  logic fifo_valid, drain;
  wr_word_t fifo_word;
  assign drain = fifo_valid && apply_ready;
  write_fifo #(.WIDTH($bits(wr_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_word),
    .out_valid(fifo_valid),
    .out_ready(drain),
    .out_data(fifo_word)
  );

  logic [7:0] out_img [0:`OUT_IMG_BYTES-1];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `OUT_IMG_BYTES; i++) out_img[i] <= 8'h00;
    end else if (ce && drain && fifo_word.addr < 5'(`OUT_IMG_BYTES)) begin
      out_img[fifo_word.addr] <= fifo_word.data;
    end
  end

  // low byte at the lowest offset for every field
  function automatic logic [31:0] w32(input logic [4:0] b);
    w32 = {out_img[b+5'h3], out_img[b+5'h2], out_img[b+5'h1], out_img[b]};
  endfunction
  function automatic logic [15:0] w16(input logic [4:0] b);
    w16 = {out_img[b+5'h1], out_img[b]};
  endfunction

  // sync mode holds a committed image until the next sync command
  logic pending, sync_mode, apply_fire;
  assign apply_fire = pending && (!sync_mode || sync_req);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 1'b0;
      sync_mode <= 1'b0;
    end else if (ce) begin
      if (drain && fifo_word.last) pending <= 1'b1;
      else if (apply_fire) pending <= 1'b0;
      if (sync_req) sync_mode <= 1'b1;
      else if (unsync_req) sync_mode <= 1'b0;
    end
  end

  logic [31:0] sp_w, range_w, half_native, range_new, clamp_top;
  logic [15:0] zero_w, restore_w, prev_zero, prev_restore;
  logic range_ok, zero_new, restore_new;
  always_comb begin
    sp_w = w32(`SP_OUT_OFS);
    range_w = w32(`RANGE_OUT_OFS);
    zero_w = w16(`ZERO_OUT_OFS);
    restore_w = w16(`RESTORE_OUT_OFS);
    // halving a positive float is one step down in the exponent
    half_native = {1'b0, native_range[30:23] - 8'h01, native_range[22:0]};
    range_ok = !range_w[31] && range_w[30:0] <= native_range[30:0]
      && range_w[30:0] >= half_native[30:0];
    zero_new = zero_w == `CMD_TRIGGER && prev_zero != `CMD_TRIGGER;
    restore_new = restore_w == `CMD_TRIGGER
      && prev_restore != `CMD_TRIGGER;
    if (restore_new) range_new = native_range;
    else if (range_ok) range_new = range_w;
    else range_new = custom_range;
    clamp_top = range_new;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      setpoint <= 32'h00000000;
      valve_op <= `VALVE_AUTO;
      custom_range <= 32'h00000000;
      eng_unit <= `UNIT_DEFAULT;
      sp_origin <= `ORIGIN_DIGITAL;
      calib_gain <= `GAIN_DEFAULT;
      medium_sel <= `MEDIUM_DEFAULT;
      prev_zero <= 16'h0000;
      prev_restore <= 16'h0000;
      range_update <= 1'b0;
      zero_pulse <= 1'b0;
      restore_pulse <= 1'b0;
    end else if (ce) begin
      range_update <= 1'b0;
      zero_pulse <= 1'b0;
      restore_pulse <= 1'b0;
      if (apply_fire) begin
        prev_zero <= zero_w;
        prev_restore <= restore_w;
        zero_pulse <= zero_new;
        if (!sp_w[31] && sp_w[30:0] > clamp_top[30:0]) begin
          setpoint <= clamp_top;
        end else begin
          setpoint <= sp_w;
        end
        valve_op <= w16(`VALVE_OUT_OFS);
        eng_unit <= w16(`UNIT_OUT_OFS);
        custom_range <= range_new;
        range_update <= range_ok || restore_new;
        if (restore_new) begin
          calib_gain <= `GAIN_DEFAULT;
          sp_origin <= `ORIGIN_DIGITAL;
          medium_sel <= `MEDIUM_DEFAULT;
          restore_pulse <= 1'b1;
        end else begin
          calib_gain <= w32(`GAIN_OUT_OFS);
          sp_origin <= w16(`ORIGIN_OUT_OFS);
          medium_sel <= w16(`MEDIUM_OUT_OFS);
        end
      end else if (custom_range == 32'h00000000) begin
        // while it is zero, as after reset, the range takes the native one
        custom_range <= native_range;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      valve_auto <= 1'b0;
      valve_close <= 1'b0;
      valve_purge <= 1'b0;
      origin_digital <= 1'b0;
    end else if (ce) begin
      valve_auto <= valve_op == `VALVE_AUTO;
      valve_close <= valve_op == `VALVE_CLOSED;
      valve_purge <= valve_op == `VALVE_PURGE;
      origin_digital <= sp_origin == `ORIGIN_DIGITAL;
    end
  end

  // freeze holds the measured part of the input image
  logic frozen;
  logic [31:0] flow_snap;
  logic [15:0] power_snap;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frozen <= 1'b0;
      flow_snap <= 32'h00000000;
      power_snap <= 16'h0000;
    end else if (ce) begin
      if (freeze_req) frozen <= 1'b1;
      else if (unfreeze_req) frozen <= 1'b0;
      if (!frozen || freeze_req) begin
        flow_snap <= meas_flow;
        power_snap <= meas_power;
      end
    end
  end

  if_state_t if_state;
  logic [15:0] quality;
  logic [8*`IN_IMG_BYTES-1:0] in_vec;
  always_comb begin
    quality = (meas_good && if_state == IF_OPER) ? `QUALITY_GOOD
      : `QUALITY_BAD;
    in_vec = '0;
    in_vec[8*`FLOW_IN_OFS +: 32] = flow_snap;
    in_vec[8*`SP_IN_OFS +: 32] = setpoint;
    in_vec[8*`VALVE_IN_OFS +: 16] = valve_op;
    in_vec[8*`POWER_IN_OFS +: 16] = power_snap;
    in_vec[8*`RANGE_IN_OFS +: 32] = custom_range;
    in_vec[8*`NATIVE_IN_OFS +: 32] = native_range;
    in_vec[8*`UNIT_IN_OFS +: 16] = eng_unit;
    in_vec[8*`ORIGIN_IN_OFS +: 16] = sp_origin;
    in_vec[8*`GAIN_IN_OFS +: 32] = calib_gain;
    in_vec[8*`MEDIUM_IN_OFS +: 16] = medium_sel;
    in_vec[8*`QUALITY_IN_OFS +: 16] = quality;
    in_vec[8*`SERIAL_IN_OFS +: 64] = serial_text;
    in_vec[8*`TYPE_IN_OFS +: 16] = PRODUCT_CODE;
    in_vec[8*`VERSION_IN_OFS +: 32] = VERSION_VALUE;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (ce) begin
      if (rd_addr < 6'(`IN_IMG_BYTES)) rd_data <= in_vec[{rd_addr, 3'b000} +: 8];
      else rd_data <= 8'h00;
    end
  end

  // three-stage sampling of the switches and the bus line
  logic [7:0] sw_s1, sw_s2, sw_s3;
  logic rx_s1, rx_s2, rx_s3;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_s1 <= 8'h00;
      sw_s2 <= 8'h00;
      sw_s3 <= 8'h00;
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
    end else if (ce) begin
      sw_s1 <= addr_switch;
      sw_s2 <= sw_s1;
      sw_s3 <= sw_s2;
      rx_s1 <= bus_rx;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end

  // address is chosen once after reset; later switch moves are ignored
  logic addr_done;
  logic [1:0] settle;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_done <= 1'b0;
      settle <= 2'h0;
      station_addr <= `DEFAULT_STATION;
      save_strobe <= 1'b0;
    end else if (ce) begin
      save_strobe <= 1'b0;
      if (settle != 2'h3) settle <= settle + 2'h1;
      if (!addr_done) begin
        if (settle == 2'h3 && sw_s2 == sw_s3) begin
          addr_done <= 1'b1;
          if (sw_s3 == 8'h00) station_addr <= `DEFAULT_STATION;
          else if (sw_s3 < `SWITCH_HIGH_LIMIT) station_addr <= sw_s3[6:0];
          else station_addr <= saved_addr;
        end
      end else if (assign_valid) begin
        station_addr <= assign_addr;
        save_strobe <= 1'b1;
      end
    end
  end

  // shortest stable low pulse approximates one bit time
  logic rx_level;
  logic [15:0] low_len;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_level <= 1'b1;
      low_len <= 16'h0001;
      baud_period <= 16'hFFFF;
    end else if (ce && rx_s2 == rx_s3) begin
      rx_level <= rx_s3;
      if (!rx_s3 && low_len != 16'hFFFF) low_len <= low_len + 16'h0001;
      if (rx_s3 && !rx_level) begin
        low_len <= 16'h0001;
        if (low_len < baud_period) baud_period <= low_len;
      end
    end
  end

  logic [31:0] flash_cnt;
  logic phase;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt <= 32'h00000000;
      phase <= 1'b0;
    end else if (ce) begin
      if (flash_cnt == 32'(FLASH_CYCLES - 1)) begin
        flash_cnt <= 32'h00000000;
        phase <= !phase;
      end else begin
        flash_cnt <= flash_cnt + 32'h00000001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      if_state <= IF_INIT;
    end else if (ce) begin
      case (if_state)
        IF_INIT: if (fault_hard) if_state <= IF_HARD;
          else if (init_done) if_state <= IF_OPER;
        IF_OPER: if (fault_hard) if_state <= IF_HARD;
          else if (fault_recov) if_state <= IF_SOFT;
        IF_SOFT: if (fault_hard) if_state <= IF_HARD;
          else if (!fault_recov) if_state <= IF_OPER;
        IF_HARD: if_state <= IF_HARD;
        default: if_state <= IF_INIT;
      endcase
    end
  end

  net_state_t net_state;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      net_state <= NET_OFF;
    end else if (ce) begin
      case (net_state)
        NET_OFF: if (data_exch) net_state <= NET_XCHG;
        NET_XCHG: if (conn_lost || !data_exch) net_state <= NET_LOST;
        NET_LOST: if (data_exch && !conn_lost) net_state <= NET_XCHG;
        default: net_state <= NET_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_left <= '{green: 1'b0, red: 1'b0};
      led_right <= '{green: 1'b0, red: 1'b0};
    end else if (ce) begin
      case (if_state)
        IF_INIT: led_left <= '{green: phase, red: !phase};
        IF_OPER: led_left <= '{green: 1'b1, red: 1'b0};
        IF_SOFT: led_left <= '{green: 1'b0, red: phase};
        default: led_left <= '{green: 1'b0, red: 1'b1};
      endcase
      case (net_state)
        NET_XCHG: led_right <= '{green: 1'b1, red: 1'b0};
        NET_LOST: led_right <= '{green: 1'b0, red: phase};
        default: led_right <= '{green: 1'b0, red: 1'b0};
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_zero_fire;
    ce && apply_fire && zero_new;
  endsequence
  a_zero_trigger: assert property (s_zero_fire |=> zero_pulse ##1 !zero_pulse)
    else $error("zero trigger not a single pulse");
  a_zero_repeat: assert property (ce && apply_fire && zero_w == prev_zero |=> !zero_pulse)
    else $error("zero repeated on unchanged value");
  a_sp_clamp: assert property (ce && apply_fire |=> setpoint[31] || setpoint[30:0] <= custom_range[30:0])
    else $error("set point above full scale");
  a_native_read: assert property (ce && rd_addr == `NATIVE_IN_OFS |=> rd_data == $past(native_range[7:0]))
    else $error("native range readback wrong");
  a_flow_read: assert property (ce && !frozen && !freeze_req ##1 ce && rd_addr == `FLOW_IN_OFS |=> rd_data == $past(meas_flow[7:0], 2))
    else $error("flow readback wrong");
  a_valve_purge: assert property (ce && valve_op == `VALVE_PURGE |=> valve_purge && !valve_auto && !valve_close)
    else $error("purge decode wrong");
  a_addr_default: assert property ($rose(addr_done) && $past(sw_s3) == 8'h00 |-> station_addr == `DEFAULT_STATION)
    else $error("default address not taken");
  a_addr_hold: assert property (addr_done && !(ce && assign_valid) |=> $stable(station_addr))
    else $error("address moved without assignment");
  a_net_green: assert property (ce && net_state == NET_XCHG |=> led_right.green && !led_right.red)
    else $error("network lamp not green in exchange");
  a_if_hard: assert property (ce && if_state == IF_HARD |=> led_left.red && !led_left.green)
    else $error("interface lamp not steady red");
  a_range_limit: assert property (ce && apply_fire && !restore_new && !range_ok |=> $stable(custom_range))
    else $error("out-of-range full scale accepted");
endmodule

// >>> verif/dp_master_model.sv
// bus master model: writes output image fields, reads input image bytes
module dp_master_model
  import fieldbus_pkg::*;
(
  input wire logic sys_clk,
  input wire logic wr_ready,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  output wr_word_t wr_word,
  output logic [5:0] rd_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    wr_valid = 1'b0;
    wr_word = '0;
    rd_addr = 6'h00;
  end
  // whole field per call, low byte first, offsets kept below 24
  task automatic put(input logic [4:0] base, input logic [31:0] v,
      input int n, input logic last);
    for (int i = 0; i < n; i++) begin
      wr_valid <= 1'b1;
      wr_word <= '{last && i == n - 1, base + 5'(i), v[8*i +: 8]};
      do begin
        @(posedge sys_clk);
      end while (!wr_ready);
    end
    wr_valid <= 1'b0;
    // released byte lane must not keep looking valid
    wr_word.data <= ~v[7:0];
    @(posedge sys_clk);
  endtask
  task automatic get(input logic [5:0] base, input int n,
      output logic [63:0] v);
    v = '0;
    for (int i = 0; i < n; i++) begin
      rd_addr <= base + 6'(i);
      @(posedge sys_clk);
      @(posedge sys_clk);
      v[8*i +: 8] = rd_data;
    end
  endtask
endmodule

// >>> verif/test_fieldbus_slave_cyclic_data.sv
// self-checking bench for the cyclic data slave
module test_fieldbus_slave_cyclic_data import fieldbus_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] PCODE = 16'h0042; // arbitrary value
  localparam logic [31:0] VER = 32'h40400000; // arbitrary value
  logic sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, bus_rx = 1'b1;
  logic freeze_req = 1'b0, unfreeze_req = 1'b0, sync_req = 1'b0;
  logic unsync_req = 1'b0, assign_valid = 1'b0, init_done = 1'b0;
  logic fault_recov = 1'b0, fault_hard = 1'b0, data_exch = 1'b0;
  logic conn_lost = 1'b0, meas_good = 1'b0, apply_ready = 1'b1;
  logic [7:0] addr_switch = 8'h00;
  logic [6:0] assign_addr = 7'h00, saved_addr = 7'h33;
  logic [15:0] meas_power = 16'h0C80;
  logic [31:0] meas_flow = 32'h41200000, native_range = 32'h42C80000;
  logic [63:0] serial_text = 64'h3837363534333231;
  logic wr_valid, wr_ready, save_strobe, valve_auto, valve_close;
  logic valve_purge, origin_digital, range_update, zero_pulse;
  logic restore_pulse;
  wr_word_t wr_word;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic [6:0] station_addr;
  logic [15:0] baud_period, valve_op, eng_unit, sp_origin, medium_sel;
  logic [31:0] setpoint, custom_range, calib_gain;
  logic [63:0] rv;
  led_t led_left, led_right;
  logic [7:0] sw_tab [5] = '{8'h00, 8'h0E, 8'h3C, 8'h7D, 8'h85};
  logic [6:0] st_tab [5] = '{7'h7E, 7'h0E, 7'h3C, 7'h7D, 7'h33};
  int error_cnt = 0, checks_done = 0, cycles = 0, g, r;
  int zero_cnt = 0, restore_cnt = 0, range_cnt = 0, save_cnt = 0;

  fieldbus_slave_cyclic_data #(.FLASH_CYCLES(4), .FIFO_DEPTH(8),
    .PRODUCT_CODE(PCODE), .VERSION_VALUE(VER)) u_fieldbus_slave_cyclic_data (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_word(wr_word), .rd_addr(rd_addr),
    .rd_data(rd_data), .freeze_req(freeze_req),
    .unfreeze_req(unfreeze_req), .sync_req(sync_req),
    .unsync_req(unsync_req), .bus_rx(bus_rx), .baud_period(baud_period),
    .addr_switch(addr_switch), .assign_valid(assign_valid),
    .assign_addr(assign_addr), .saved_addr(saved_addr),
    .save_strobe(save_strobe), .station_addr(station_addr),
    .init_done(init_done), .fault_recov(fault_recov),
    .fault_hard(fault_hard), .data_exch(data_exch),
    .conn_lost(conn_lost), .led_left(led_left), .led_right(led_right),
    .meas_flow(meas_flow), .meas_power(meas_power),
    .meas_good(meas_good), .native_range(native_range),
    .serial_text(serial_text), .apply_ready(apply_ready),
    .setpoint(setpoint), .valve_op(valve_op),
    .custom_range(custom_range), .eng_unit(eng_unit),
    .sp_origin(sp_origin), .calib_gain(calib_gain), .medium_sel(medium_sel),
    .valve_auto(valve_auto), .valve_close(valve_close),
    .valve_purge(valve_purge), .origin_digital(origin_digital),
    .range_update(range_update), .zero_pulse(zero_pulse),
    .restore_pulse(restore_pulse));

  dp_master_model u_dp_master_model (.sys_clk(sys_clk),
    .wr_ready(wr_ready), .rd_data(rd_data), .wr_valid(wr_valid),
    .wr_word(wr_word), .rd_addr(rd_addr));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // pulses are counted, so a missed or doubled one shows in the totals
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    zero_cnt <= zero_cnt + int'(zero_pulse);
    restore_cnt <= restore_cnt + int'(restore_pulse);
    range_cnt <= range_cnt + int'(range_update);
    save_cnt <= save_cnt + int'(save_strobe);
    if (cycles == 30000) begin
      error_cnt++;
      final_report();
    end
  end

  task check(input string name, input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task do_reset(input logic [7:0] sw);
    addr_switch <= sw;
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
  endtask
  // the fixed wait covers fifo drain, commit and decode latency
  task wr(input logic [4:0] a, input logic [31:0] v, input int n);
    u_dp_master_model.put(a, v, n, 1'b1);
    repeat (12) @(posedge sys_clk);
  endtask
  task rd(input logic [5:0] a, input int n);
    u_dp_master_model.get(a, n, rv);
  endtask
  task scan(input bit right, output int gn, rn);
    gn = 0;
    rn = 0;
    repeat (24) begin
      @(posedge sys_clk);
      gn += int'(right ? led_right.green : led_left.green);
      rn += int'(right ? led_right.red : led_left.red);
    end
  endtask

  initial begin
    foreach (sw_tab[i]) begin
      do_reset(sw_tab[i]);
      check("station", station_addr, st_tab[i]);
    end
    g = save_cnt;
    assign_addr <= 7'h15;
    assign_valid <= 1'b1;
    @(posedge sys_clk);
    assign_valid <= 1'b0;
    addr_switch <= 8'h01;
    repeat (8) @(posedge sys_clk);
    check("assigned", station_addr, 7'h15);
    check("saves", save_cnt - g, 1);
    do_reset(8'h0E);
    scan(0, g, r);
    check("init lamp", (g + r) * 2 + (g > 0 && r > 0), 49);
    scan(1, g, r);
    check("net off", g + r, 0);
    init_done <= 1'b1;
    data_exch <= 1'b1;
    meas_good <= 1'b1;
    repeat (3) @(posedge sys_clk);
    scan(0, g, r);
    check("oper lamp", r * 100 + g, 24);
    scan(1, g, r);
    check("xchg lamp", r * 100 + g, 24);
    rd(6'h00, 4);
    check("flow", rv, meas_flow);
    rd(6'h10, 4);
    check("native", rv, native_range);
    rd(6'h20, 8);
    check("serial", rv, serial_text);
    rd(6'h28, 6);
    check("type ver", rv, {16'h0000, VER, PCODE});
    rd(6'h2E, 1);
    check("unmapped", rv, 0);
    rd(6'h1E, 2);
    check("good", rv, 16'h0001);
    meas_good <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(6'h1E, 2);
    check("bad", rv, 16'h0000);
    meas_good <= 1'b1;
    // stall the drain so eight bytes fill the fifo
    apply_ready <= 1'b0;
    u_dp_master_model.put(5'h00, 32'h42480000, 4, 1'b0);
    u_dp_master_model.put(5'h0E, 32'h40000000, 4, 1'b1);
    check("full", wr_ready, 0);
    apply_ready <= 1'b1;
    repeat (20) @(posedge sys_clk);
    check("setpoint", setpoint, 32'h42480000);
    check("gain", calib_gain, 32'h40000000);
    wr(5'h00, 32'h43480000, 4);
    check("clamp", setpoint, 32'h42C80000);
    rd(6'h04, 4);
    check("sp back", rv, 32'h42C80000);
    g = range_cnt;
    wr(5'h06, 32'h42200000, 4);
    check("low range", custom_range, 32'h42C80000);
    wr(5'h06, 32'h42A00000, 4);
    check("range", custom_range, 32'h42A00000);
    check("rescale", range_cnt - g, 1);
    rd(6'h0C, 4);
    check("range back", rv, 32'h42A00000);
    for (int m = 1; m < 4; m++) begin
      wr(5'h04, 32'(m), 2);
      check("valve", {valve_purge, valve_close, valve_auto}, 1 << (m - 1));
      rd(6'h08, 2);
      check("valve back", rv, m);
      check("valve op", valve_op, m);
    end
    wr(5'h0C, 32'h1, 2);
    check("digital", origin_digital, 1);
    wr(5'h0C, 32'h2, 2);
    check("analog", origin_digital, 0);
    rd(6'h16, 2);
    check("origin back", rv, 2);
    check("origin", sp_origin, 2);
    wr(5'h0A, 32'h7, 2);
    check("unit", eng_unit, 7);
    g = zero_cnt;
    wr(5'h14, 32'hA5, 2);
    wr(5'h14, 32'hA5, 2);
    check("zero once", zero_cnt - g, 1);
    wr(5'h14, 32'h5A, 2);
    wr(5'h14, 32'hA5, 2);
    check("zero again", zero_cnt - g, 2);
    wr(5'h16, 32'hA5, 2);
    check("restore", restore_cnt, 1);
    check("gain dflt", calib_gain, 32'h3F800000);
    check("medium dflt", medium_sel, 1);
    sync_req <= 1'b1;
    @(posedge sys_clk);
    sync_req <= 1'b0;
    wr(5'h00, 32'h41200000, 4);
    check("held", setpoint, 32'h42C80000);
    sync_req <= 1'b1;
    @(posedge sys_clk);
    sync_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("synced", setpoint, 32'h41200000);
    freeze_req <= 1'b1;
    @(posedge sys_clk);
    freeze_req <= 1'b0;
    meas_flow <= 32'h41A00000;
    rd(6'h00, 4);
    check("frozen", rv, 32'h41200000);
    unfreeze_req <= 1'b1;
    @(posedge sys_clk);
    unfreeze_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(6'h00, 4);
    check("thawed", rv, 32'h41A00000);
    conn_lost <= 1'b1;
    fault_recov <= 1'b1;
    repeat (3) @(posedge sys_clk);
    scan(1, g, r);
    check("lost", g * 100 + (r > 0 && r < 24), 1);
    scan(0, g, r);
    check("soft", g * 100 + (r > 0 && r < 24), 1);
    fault_hard <= 1'b1;
    repeat (3) @(posedge sys_clk);
    scan(0, g, r);
    check("hard", g * 100 + r, 24);
    bus_rx <= 1'b0;
    repeat (20) @(posedge sys_clk);
    bus_rx <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check("baud", baud_period, 20);
    final_report();
  end
endmodule
